// ==== irq_flag_pkg.sv ====
// ============================================================================
// Function
// (RULE1) Edge select picks rising or falling edge
// (RULE2) Valid pin edge sets pin flag
// (RULE3) Pin request needs its enable bit
// (RULE4) Software clears pin flag; hardware never does
// (RULE5) Pin wakes sleep only if armed before
// (RULE6) Wake branches to vector only with global enable
// (RULE7) Timer wrap from max to zero sets flag
// (RULE8) Timer enable gates request; flag still records
// (RULE9) Upper port pin change sets change flag
// (RULE10) Port change enable gates its request
// (RULE11) Pin flag sets only in fourth/first phase
// (RULE12) Request is flag and enable, global gated
// (RULE13) Flags stay set until software clears
package irq_flag_pkg;

  // ==========================================================================
  // Register map, byte addresses on the APB.
  localparam int                ADDR_W         = 12;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_CTRL  = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_OPTION    = 12'h004;
  localparam logic [ADDR_W-1:0] ADDR_TIMER     = 12'h008;
  localparam logic [ADDR_W-1:0] ADDR_SLEEP     = 12'h00c;

  // ==========================================================================
  // Field positions of irq_control_reg.
  localparam int BIT_GLOBAL_EN   = 7;
  localparam int BIT_PERIPH_EN   = 6;
  localparam int BIT_TIMER_EN    = 5;
  localparam int BIT_EXT_EN      = 4;
  localparam int BIT_PORT_EN     = 3;
  localparam int BIT_TIMER_FLAG  = 2;
  localparam int BIT_EXT_FLAG    = 1;
  localparam int BIT_PORT_FLAG   = 0;

  // Field positions of the option and sleep registers.
  localparam int BIT_EDGE_POL    = 6;
  localparam int BIT_SLEEP       = 0;
  localparam int BIT_WAKE_ARMED  = 1;

  // ==========================================================================
  // Reset values, and the timer maximum and step.
  localparam logic [7:0] CTRL_RESET     = 8'h00;
  localparam logic       EDGE_POL_RESET = 1'b1;
  localparam logic [7:0] TIMER_RESET    = 8'h00;
  localparam logic [7:0] TIMER_MAX      = 8'hff;
  localparam logic [7:0] TIMER_STEP     = 8'h01;

  // ==========================================================================
  // Widths of the watched inputs.
  localparam int EXT_W  = 1;
  localparam int PORT_W = 4;

  // ==========================================================================
  // Quarter-cycle phases of one instruction cycle.
  typedef enum logic [1:0]
  {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b10,
    PH_Q4 = 2'b11
  } phase_type;

endpackage : irq_flag_pkg

// ==== change_if.sv ====
`timescale 1ns/1ps
`default_nettype none

// ============================================================================
// Sampled level and its rising and falling edges, per bit.
interface change_if #(parameter int W = 1);
  logic [W-1:0] level;
  logic [W-1:0] rose;
  logic [W-1:0] fell;

  modport detector (input level, output rose, output fell);
  modport user     (output level, input rose, input fell);
endinterface : change_if

`default_nettype wire

// ==== change_detect.sv ====
`timescale 1ns/1ps
`default_nettype none

// ============================================================================
// Edge detector for synchronous inputs; one flop of history per bit.
module change_detect #(parameter int W = 1)
(
  input  wire logic  pclk,
  input  wire logic  presetn,
  change_if.detector chg
);

  logic [W-1:0] prev_r;

  // The history flop resets low, so an input held high at reset looks like
  // a rising edge on the first clock; the owner masks that with its own prime.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prev_r <= '0;
    else
      prev_r <= chg.level;
  end

  // Edges are combinational here; the owner registers what it uses.
  assign chg.rose = chg.level & ~prev_r;
  assign chg.fell = ~chg.level & prev_r;

endmodule : change_detect

`default_nettype wire

// ==== irq_flag_logic.sv ====
`timescale 1ns/1ps
`default_nettype none

// ============================================================================
// Core interrupt flag logic: pin edge, timer wrap and port change sources.
module irq_flag_logic
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ext_irq_pin,
  input  wire logic [3:0]  second_io_port_hi,
  output logic             irq_request,
  output logic             sleep_state,
  output logic             wake_pulse,
  output logic             vector_branch,
  output logic      [1:0]  q_phase
);

  // ==========================================================================
  // Declarations.
  irq_flag_pkg::phase_type ph_r;
  irq_flag_pkg::phase_type ph_nxt;
  logic                    global_irq_enable_r;
  logic                    periph_enable_r;
  logic                    timer_wrap_enable_r;
  logic                    ext_pin_irq_enable_r;
  logic                    port_change_enable_r;
  logic                    timer_wrap_flag_r;
  logic                    ext_pin_irq_flag_r;
  logic                    port_change_flag_r;
  logic                    edge_polarity_select_r;
  logic [7:0]              eight_bit_timer_count_r;
  logic                    ext_pend_r;
  logic                    primed_r;
  logic                    sleep_r;
  logic                    wake_arm_r;
  logic                    pready_r;
  logic                    pslverr_r;
  logic [31:0]             prdata_r;
  logic                    irq_request_r;
  logic                    wake_pulse_r;
  logic                    vector_branch_r;
  logic                    apb_wr;
  logic                    ctrl_wr;
  logic                    opt_wr;
  logic                    tmr_wr;
  logic                    slp_wr;
  logic                    mapped;
  logic [7:0]              ctrl_rd;
  logic [7:0]              rd_byte;
  logic                    valid_edge;
  logic                    ext_commit;
  logic                    timer_tick;
  logic                    timer_wrap;
  logic                    port_event;
  logic                    wake_cause;
  logic                    any_pending;

  change_if #(.W(irq_flag_pkg::EXT_W))  ext_chg ();
  change_if #(.W(irq_flag_pkg::PORT_W)) port_chg ();

  // ==========================================================================
  // Edge detectors for the pin and the upper port nibble.
  assign ext_chg.level  = ext_irq_pin;
  assign port_chg.level = second_io_port_hi;

  change_detect #(.W(irq_flag_pkg::EXT_W)) u_ext_det
  (
    .pclk    (pclk),
    .presetn (presetn),
    .chg     (ext_chg.detector)
  );

  change_detect #(.W(irq_flag_pkg::PORT_W)) u_port_det
  (
    .pclk    (pclk),
    .presetn (presetn),
    .chg     (port_chg.detector)
  );

  // Ignore edges in the first cycle after reset, when history is not valid.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      primed_r <= 1'b0;
    else
      primed_r <= 1'b1;
  end

  // ==========================================================================
  // Quarter-cycle phase sequencer, Q1 to Q4 and round again.
  always_comb
  begin
    case (ph_r)
      irq_flag_pkg::PH_Q1: ph_nxt = irq_flag_pkg::PH_Q2;
      irq_flag_pkg::PH_Q2: ph_nxt = irq_flag_pkg::PH_Q3;
      irq_flag_pkg::PH_Q3: ph_nxt = irq_flag_pkg::PH_Q4;
      irq_flag_pkg::PH_Q4: ph_nxt = irq_flag_pkg::PH_Q1;
      default:             ph_nxt = irq_flag_pkg::PH_Q1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ph_r <= irq_flag_pkg::PH_Q1;
    else
      ph_r <= ph_nxt;
  end

  // ==========================================================================
  // APB decode. A write lands on the access edge where pready is high.
  assign apb_wr  = psel && penable && pready_r && pwrite;
  assign ctrl_wr = apb_wr && (paddr == irq_flag_pkg::ADDR_IRQ_CTRL);
  assign opt_wr  = apb_wr && (paddr == irq_flag_pkg::ADDR_OPTION);
  assign tmr_wr  = apb_wr && (paddr == irq_flag_pkg::ADDR_TIMER);
  assign slp_wr  = apb_wr && (paddr == irq_flag_pkg::ADDR_SLEEP);
  assign mapped  = (paddr == irq_flag_pkg::ADDR_IRQ_CTRL) ||
                   (paddr == irq_flag_pkg::ADDR_OPTION)   ||
                   (paddr == irq_flag_pkg::ADDR_TIMER)    ||
                   (paddr == irq_flag_pkg::ADDR_SLEEP);

  assign ctrl_rd = {global_irq_enable_r, periph_enable_r, timer_wrap_enable_r,
                    ext_pin_irq_enable_r, port_change_enable_r, timer_wrap_flag_r,
                    ext_pin_irq_flag_r, port_change_flag_r};

  // Read mux; unmapped addresses read zero and raise pslverr.
  always_comb
  begin
    rd_byte = 8'h00;
    case (paddr)
      irq_flag_pkg::ADDR_IRQ_CTRL: rd_byte = ctrl_rd;
      irq_flag_pkg::ADDR_OPTION:
        rd_byte[irq_flag_pkg::BIT_EDGE_POL] = edge_polarity_select_r;
      irq_flag_pkg::ADDR_TIMER:    rd_byte = eight_bit_timer_count_r;
      irq_flag_pkg::ADDR_SLEEP:
      begin
        rd_byte[irq_flag_pkg::BIT_SLEEP]      = sleep_r;
        rd_byte[irq_flag_pkg::BIT_WAKE_ARMED] = wake_arm_r;
      end
      default:                     rd_byte = 8'h00;
    endcase
  end

  // No wait state: data is captured in setup, so every output is a flop.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= '0;
    end
    else if (psel && !penable)
    begin
      pready_r  <= 1'b1;
      pslverr_r <= !mapped;
      prdata_r  <= {24'h000000, rd_byte};
    end
    else
    begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end
  end

  // ==========================================================================
  // Enable bits and the edge polarity select.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      global_irq_enable_r    <= irq_flag_pkg::CTRL_RESET[irq_flag_pkg::BIT_GLOBAL_EN];
      periph_enable_r        <= irq_flag_pkg::CTRL_RESET[irq_flag_pkg::BIT_PERIPH_EN];
      timer_wrap_enable_r    <= irq_flag_pkg::CTRL_RESET[irq_flag_pkg::BIT_TIMER_EN];
      ext_pin_irq_enable_r   <= irq_flag_pkg::CTRL_RESET[irq_flag_pkg::BIT_EXT_EN];
      port_change_enable_r   <= irq_flag_pkg::CTRL_RESET[irq_flag_pkg::BIT_PORT_EN];
      edge_polarity_select_r <= irq_flag_pkg::EDGE_POL_RESET;
    end
    else
    begin
      if (ctrl_wr)
      begin
        global_irq_enable_r  <= pwdata[irq_flag_pkg::BIT_GLOBAL_EN];
        periph_enable_r      <= pwdata[irq_flag_pkg::BIT_PERIPH_EN];
        timer_wrap_enable_r  <= pwdata[irq_flag_pkg::BIT_TIMER_EN];   // [RULE8]
        ext_pin_irq_enable_r <= pwdata[irq_flag_pkg::BIT_EXT_EN];     // [RULE3]
        port_change_enable_r <= pwdata[irq_flag_pkg::BIT_PORT_EN];    // [RULE10]
      end
      if (opt_wr)
        edge_polarity_select_r <= pwdata[irq_flag_pkg::BIT_EDGE_POL];
    end
  end

  // ==========================================================================
  // Pin edge: caught at once, committed to the flag only in Q4 or Q1.
  assign valid_edge = primed_r && (edge_polarity_select_r ? ext_chg.rose[0]
                                                          : ext_chg.fell[0]);  // [RULE1]
  assign ext_commit = ext_pend_r && ((ph_r == irq_flag_pkg::PH_Q4) ||
                                     (ph_r == irq_flag_pkg::PH_Q1));           // [RULE11]

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ext_pend_r <= 1'b0;
    else
      ext_pend_r <= valid_edge || (ext_pend_r && !ext_commit);
  end

  // ==========================================================================
  // Timer: one count per instruction cycle, halted in sleep.
  assign timer_tick = (ph_r == irq_flag_pkg::PH_Q4) && !sleep_r && !tmr_wr;
  assign timer_wrap = timer_tick && (eight_bit_timer_count_r == irq_flag_pkg::TIMER_MAX);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      eight_bit_timer_count_r <= irq_flag_pkg::TIMER_RESET;
    else if (tmr_wr)
      eight_bit_timer_count_r <= pwdata[7:0];
    else if (timer_tick)
      eight_bit_timer_count_r <= eight_bit_timer_count_r + irq_flag_pkg::TIMER_STEP;
  end

  assign port_event = primed_r && ((|port_chg.rose) || (|port_chg.fell));

  // ==========================================================================
  // Sticky flags. A hardware set in the same cycle as a software write wins,
  // so an event is never lost to a clear that raced it.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      timer_wrap_flag_r  <= irq_flag_pkg::CTRL_RESET[irq_flag_pkg::BIT_TIMER_FLAG];
      ext_pin_irq_flag_r <= irq_flag_pkg::CTRL_RESET[irq_flag_pkg::BIT_EXT_FLAG];
      port_change_flag_r <= irq_flag_pkg::CTRL_RESET[irq_flag_pkg::BIT_PORT_FLAG];
    end
    else
    begin
      timer_wrap_flag_r  <= timer_wrap ||
                            (ctrl_wr ? pwdata[irq_flag_pkg::BIT_TIMER_FLAG]
                                     : timer_wrap_flag_r);             // [RULE7] [RULE13]
      ext_pin_irq_flag_r <= ext_commit ||
                            (ctrl_wr ? pwdata[irq_flag_pkg::BIT_EXT_FLAG]
                                     : ext_pin_irq_flag_r);            // [RULE2] [RULE4]
      port_change_flag_r <= port_event ||
                            (ctrl_wr ? pwdata[irq_flag_pkg::BIT_PORT_FLAG]
                                     : port_change_flag_r);            // [RULE9] [RULE13]
    end
  end

  // ==========================================================================
  // Request to the core: any flag with its enable, gated globally.
  assign any_pending = (ext_pin_irq_flag_r && ext_pin_irq_enable_r) ||
                       (timer_wrap_flag_r && timer_wrap_enable_r) ||
                       (port_change_flag_r && port_change_enable_r);    // [RULE3] [RULE8]

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_request_r <= 1'b0;
    else
      irq_request_r <= global_irq_enable_r && any_pending;             // [RULE12]
  end

  // ==========================================================================
  // Sleep and wake. The pin enable is frozen at sleep entry, so enabling it
  // while asleep does not let the pin wake the core.
  assign wake_cause = sleep_r &&
                      ((ext_pin_irq_flag_r && wake_arm_r) ||
                       (timer_wrap_flag_r && timer_wrap_enable_r) ||
                       (port_change_flag_r && port_change_enable_r));   // [RULE5]

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sleep_r    <= 1'b0;
      wake_arm_r <= 1'b0;
    end
    else if (wake_cause)
      sleep_r <= 1'b0;
    else if (slp_wr && pwdata[irq_flag_pkg::BIT_SLEEP] && !sleep_r)
    begin
      sleep_r    <= 1'b1;
      wake_arm_r <= ext_pin_irq_enable_r;                               // [RULE5]
    end
  end

  // Wake pulse, with the branch decision taken from the global enable.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wake_pulse_r    <= 1'b0;
      vector_branch_r <= 1'b0;
    end
    else
    begin
      wake_pulse_r    <= wake_cause;
      vector_branch_r <= wake_cause && global_irq_enable_r;             // [RULE6]
    end
  end

  // ==========================================================================
  // Outputs, all straight from flops.
  assign prdata        = prdata_r;
  assign pready        = pready_r;
  assign pslverr       = pslverr_r;
  assign irq_request   = irq_request_r;
  assign sleep_state   = sleep_r;
  assign wake_pulse    = wake_pulse_r;
  assign vector_branch = vector_branch_r;
  assign q_phase       = ph_r;

  // ==========================================================================
  // Assertions.
  a_ext_edge_flag: assert property (@(posedge pclk) disable iff (!presetn) // [RULE2]
    valid_edge |-> ##[1:4] ext_pin_irq_flag_r)
    else $error("Valid pin edge did not set the pin flag.");

  a_ext_set_phase: assert property (@(posedge pclk) disable iff (!presetn) // [RULE11]
    $rose(ext_pin_irq_flag_r) && !$past(ctrl_wr) |->
      ($past(ph_r) == irq_flag_pkg::PH_Q4) || ($past(ph_r) == irq_flag_pkg::PH_Q1))
    else $error("Pin flag set outside the Q4-Q1 window.");

  a_wrong_edge_quiet: assert property (@(posedge pclk) disable iff (!presetn) // [RULE1]
    !edge_polarity_select_r && ext_chg.rose[0] && !ext_pend_r |=> !ext_pend_r)
    else $error("Rising edge taken while falling edge selected.");

  a_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn) // [RULE13]
    ext_pin_irq_flag_r && !ctrl_wr |=> ext_pin_irq_flag_r)
    else $error("Pin flag cleared without a software write.");

  a_timer_wrap_flag: assert property (@(posedge pclk) disable iff (!presetn) // [RULE7]
    timer_wrap |=> timer_wrap_flag_r && (eight_bit_timer_count_r == 8'h00))
    else $error("Timer wrap did not set the flag.");

  a_port_change_flag: assert property (@(posedge pclk) disable iff (!presetn) // [RULE9]
    port_event |=> port_change_flag_r)
    else $error("Port change did not set the flag.");

  a_irq_gated: assert property (@(posedge pclk) disable iff (!presetn) // [RULE12]
    !global_irq_enable_r || !any_pending |=> !irq_request_r)
    else $error("Request raised without global enable and pending source.");

  a_ext_enable_gate: assert property (@(posedge pclk) disable iff (!presetn) // [RULE3]
    global_irq_enable_r && ext_pin_irq_flag_r && !ext_pin_irq_enable_r &&
    !timer_wrap_flag_r && !port_change_flag_r |=> !irq_request_r)
    else $error("Disabled pin source raised a request.");

  a_unarmed_no_wake: assert property (@(posedge pclk) disable iff (!presetn) // [RULE5]
    sleep_r && !wake_arm_r && !timer_wrap_flag_r && !port_change_flag_r |=> !wake_pulse_r)
    else $error("Pin woke the core without being armed.");

  a_vector_gie: assert property (@(posedge pclk) disable iff (!presetn) // [RULE6]
    wake_pulse_r |-> (vector_branch_r == $past(global_irq_enable_r)) && !sleep_r)
    else $error("Vector branch does not follow the global enable.");

  c_ext_wake: cover property (@(posedge pclk) disable iff (!presetn)
    sleep_r && wake_arm_r ##[1:20] wake_pulse_r && vector_branch_r);
  c_timer_irq: cover property (@(posedge pclk) disable iff (!presetn)
    timer_wrap ##[1:4] irq_request_r);
  c_set_beats_clear: cover property (@(posedge pclk) disable iff (!presetn)
    ext_commit && ctrl_wr && !pwdata[irq_flag_pkg::BIT_EXT_FLAG]);

endmodule : irq_flag_logic

`default_nettype wire

// ==== pin_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ============================================================================
// Far-side pins: the external interrupt pin and the upper port pins.
module pin_model
(
  input  wire logic       pclk,
  output logic            ext_irq_pin,
  output logic      [3:0] second_io_port_hi
);
  // Both lines start low so the first edge is a clean rise.
  initial
  begin
    ext_irq_pin       = 1'b0;
    second_io_port_hi = 4'h0;
  end

  // Moves the pin just after a rising edge; the design samples it synchronously.
  task set_pin(input logic lvl);
    @(posedge pclk);
    ext_irq_pin <= lvl;
  endtask : set_pin

  // Flips one upper port pin, which is a single input change.
  task flip_port(input int b);
    @(posedge pclk);
    second_io_port_hi[b] <= ~second_io_port_hi[b];
  endtask : flip_port
endmodule : pin_model

`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none

// ============================================================================
// Bench for the interrupt flag logic, driven over its register bus.
module tb_top;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        ext_irq_pin;
  logic [3:0]  port_hi;
  logic        irq_request;
  logic        sleep_state;
  logic        wake_pulse;
  logic        vector_branch;
  logic [1:0]  q_phase;
  logic [1:0]  ph0;
  logic [31:0] rd;
  logic        er;
  logic        vec_seen;
  int          errors;
  int          check_count;
  int          wakes = 0;

  irq_flag_logic i_irq_flag_logic (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_irq_pin(ext_irq_pin),
    .second_io_port_hi(port_hi), .irq_request(irq_request),
    .sleep_state(sleep_state), .wake_pulse(wake_pulse),
    .vector_branch(vector_branch), .q_phase(q_phase));

  pin_model i_pin_model (.pclk(pclk), .ext_irq_pin(ext_irq_pin),
    .second_io_port_hi(port_hi));

  // Free-running 50 MHz clock.
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // Wake pulses last one cycle, so they are latched here and counted.
  always @(posedge pclk)
  begin
    if (wake_pulse === 1'b1)
    begin
      wakes    <= wakes + 1;
      vec_seen <= vector_branch;
    end
  end

  // ==========================================================================
  // Helpers.
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One transfer; the request is held until pready is seen high at an edge.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
      errors++;
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wctl(input logic [31:0] d);
    apb(1'b1, irq_flag_pkg::ADDR_IRQ_CTRL, d);
  endtask : wctl

  task rchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h00000000);
    chk(rd & m, e);
  endtask : rchk

  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  // Bounded wait for one more wake pulse.
  task wait_wake(input int w0);
    int n;
    n = 0;
    while (wakes == w0 && n < 30)
    begin
      @(posedge pclk);
      n++;
    end
    chk(wakes, w0 + 1);
  endtask : wait_wake

  // Sleeps with the given control value, then wakes it with a pin rise.
  task sleep_run(input logic [7:0] ctl, input logic vec);
    int w0;
    w0 = wakes;
    wctl({24'h000000, ctl});
    apb(1'b1, irq_flag_pkg::ADDR_SLEEP, 32'h00000001);
    cyc(1);
    chk(sleep_state, 1'b1);
    rchk(irq_flag_pkg::ADDR_SLEEP, 32'h00000003, 32'h00000003);
    i_pin_model.set_pin(1'b1);
    wait_wake(w0);
    chk(vec_seen, vec);
    i_pin_model.set_pin(1'b0);
  endtask : sleep_run

  task results();
    $display("TB: checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : results

  // Generous limit; the tests need well under a thousand cycles.
  initial
  begin
    #200000;
    errors++;
    results();
  end

  // ==========================================================================
  // Test sequence.
  initial
  begin
    int w0;
    errors = 0;
    check_count = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rchk(irq_flag_pkg::ADDR_IRQ_CTRL, 32'hffffffff, 32'h00000000);
    rchk(irq_flag_pkg::ADDR_OPTION, 32'hffffffff, 32'h00000040);
    rchk(irq_flag_pkg::ADDR_SLEEP, 32'hffffffff, 32'h00000000);
    apb(1'b0, 12'h010, 32'h00000000);
    chk({31'h0, er}, 32'h00000001);
    // The phase counter steps once per clock, so two samples differ by one.
    ph0 = q_phase;
    cyc(1);
    chk({30'h0, q_phase}, {30'h0, ph0 + 2'h1});
    $display("test reset done");
    // Every polarity against every edge direction.
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, irq_flag_pkg::ADDR_OPTION, i[1] ? 32'h00000000 : 32'h00000040);
      wctl(32'h00000000);
      i_pin_model.set_pin(~i[0]);
      cyc(8);
      rchk(irq_flag_pkg::ADDR_IRQ_CTRL, 32'h02, (i[1] == i[0]) ? 32'h02 : 32'h0);
    end
    $display("test polarity done");
    apb(1'b1, irq_flag_pkg::ADDR_OPTION, 32'h00000040);
    wctl(32'h00000090);
    i_pin_model.set_pin(1'b1);
    cyc(8);
    chk(irq_request, 1'b1);
    wctl(32'h00000012);
    cyc(2);
    chk(irq_request, 1'b0);
    wctl(32'h00000082);
    cyc(2);
    chk(irq_request, 1'b0);
    rchk(irq_flag_pkg::ADDR_IRQ_CTRL, 32'h02, 32'h02);
    wctl(32'h00000080);
    rchk(irq_flag_pkg::ADDR_IRQ_CTRL, 32'h02, 32'h00);
    i_pin_model.set_pin(1'b0);
    $display("test pin enable done");
    for (int b = 0; b < 4; b++)
    begin
      wctl(32'h00000000);
      i_pin_model.flip_port(b);
      cyc(4);
      rchk(irq_flag_pkg::ADDR_IRQ_CTRL, 32'h01, 32'h01);
    end
    wctl(32'h00000089);
    cyc(2);
    chk(irq_request, 1'b1);
    wctl(32'h00000081);
    cyc(2);
    chk(irq_request, 1'b0);
    $display("test port change done");
    wctl(32'h000000a0);
    apb(1'b1, irq_flag_pkg::ADDR_TIMER, {24'h000000, irq_flag_pkg::TIMER_MAX});
    cyc(8);
    rchk(irq_flag_pkg::ADDR_IRQ_CTRL, 32'h04, 32'h04);
    chk(irq_request, 1'b1);
    wctl(32'h00000084);
    cyc(2);
    chk(irq_request, 1'b0);
    rchk(irq_flag_pkg::ADDR_IRQ_CTRL, 32'h04, 32'h04);
    $display("test timer done");
    sleep_run(8'h10, 1'b0);
    sleep_run(8'h90, 1'b1);
    w0 = wakes;
    wctl(32'h00000000);
    apb(1'b1, irq_flag_pkg::ADDR_SLEEP, 32'h00000001);
    i_pin_model.set_pin(1'b1);
    cyc(10);
    chk(sleep_state, 1'b1);
    rchk(irq_flag_pkg::ADDR_SLEEP, 32'h00000003, 32'h00000001);
    wctl(32'h00000008);
    i_pin_model.flip_port(0);
    wait_wake(w0);
    chk(vec_seen, 1'b0);
    $display("test sleep done");
    results();
  end
endmodule : tb_top

`default_nettype wire
